// ### pkg/cpu_exec_pkg.sv
// shared constants, operation codes and carriers for the execute block
// assumes a decoder upstream fills exec_cmd_s and one core clock
package cpu_exec_pkg;

    // status flag bit positions in status_flags_register
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;
    localparam int         MSB         = 7;

    // pointer selection and addressing modes
    localparam logic [1:0] PTR_X = 2'h0;
    localparam logic [1:0] PTR_Y = 2'h1;
    localparam logic [1:0] PTR_Z = 2'h2;

    typedef enum logic [1:0] {
        MODE_PLAIN,
        MODE_POST_INC,
        MODE_PRE_DEC,
        MODE_DISP
    } ptr_mode_e;

    typedef enum logic [4:0] {
        OP_NONE,
        OP_BRANCH_FLAG_SET,
        OP_BRANCH_FLAG_CLEAR,
        OP_BRANCH_SIGNED_GE,
        OP_BRANCH_SIGNED_LESS,
        OP_IO_BIT_FORCE_ONE,
        OP_IO_BIT_FORCE_ZERO,
        OP_SHIFT_LEFT_LOGICAL,
        OP_SHIFT_RIGHT_LOGICAL,
        OP_SHIFT_RIGHT_ARITHMETIC,
        OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY,
        OP_FLAG_FORCE_ONE_INDEXED,
        OP_FLAG_FORCE_ZERO_INDEXED,
        OP_COPY_BIT_TO_TRANSFER,
        OP_COPY_TRANSFER_TO_BIT,
        OP_POINTER_LOAD
    } op_e;

    // one decoded instruction
    typedef struct packed {
        op_e       code;
        logic [4:0] reg_idx;
        logic [2:0] bit_idx;
        logic [6:0] offset;
        logic [5:0] disp;
        logic [1:0] ptr;
        ptr_mode_e  mode;
        logic [4:0] io_addr;
    } exec_cmd_s;

endpackage

// ### rtl/cpu_branch_bit_load_exec.sv
// execute unit for branches, bit, shift, flag and indirect load operations
// assumes a register file, data memory and io space answering in-cycle
// What this block does
// - single flag branch: when condition holds pc gets pc plus offset plus one
// - signed ge branches on n xor v zero, signed less on one
// - interrupt enable branches test global enable one or zero
// - io bit force one or zero in two cycles, flags untouched
// - logical shift left, zero into bit 0, updates z c n v
// - logical shift right, zero into bit 7, updates z c n v
// - arithmetic shift right keeps bit 7, updates z c n v
// - rotate left through carry, carry from bit 7
// - rotate right through carry, carry from bit 0
// - set a chosen flag to one in one cycle, others kept
// - clear a chosen flag to zero in one cycle, others kept
// - copy a chosen register bit into the transfer flag
// - copy the transfer flag into a chosen register bit
// - indirect load through x y z, optional post increment, two cycles
// - pre decrement pointer first, then load from new address
// - displacement load from y or z plus constant, pointer kept
`timescale 1ns/100ps

module cpu_branch_bit_load_exec
    import cpu_exec_pkg::*;
#(
    parameter int PC_W   = 12,
    parameter int ADDR_W = 16
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // command from decoder
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire exec_cmd_s         cmd,
    // register file
    input  wire logic [7:0]        rd_value,
    output logic                   rd_we,
    output logic [4:0]             rd_waddr,
    output logic [7:0]             rd_wdata,
    // pointer pair
    input  wire logic [ADDR_W-1:0] ptr_value,
    output logic                   ptr_we,
    output logic [1:0]             ptr_sel,
    output logic [ADDR_W-1:0]      ptr_wdata,
    // data memory
    output logic                   dmem_re,
    output logic [ADDR_W-1:0]      dmem_addr,
    input  wire logic [7:0]        dmem_rdata,
    // io space
    output logic                   io_re,
    output logic                   io_we,
    output logic [4:0]             io_addr,
    output logic [7:0]             io_wdata,
    input  wire logic [7:0]        io_rdata,
    // core state
    output logic [PC_W-1:0]        pc,
    output logic [7:0]             status_flags,
    output logic                   done
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BRANCH,
        ST_IO,
        ST_LOAD
    } state_e;

    state_e          state_r;
    state_e          state_nxt;
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] target_r;
    logic [7:0]      flags_r;
    logic [7:0]      flags_nxt;
    logic            take;
    logic            cond;
    logic [7:0]      shift_res;
    logic            shift_c;
    logic            is_shift;
    logic [2:0]      bit_r;
    logic            io_one_r;
    logic [4:0]      ld_reg_r;
    logic            ld_wb_ptr_r;
    logic [ADDR_W-1:0] ld_ptr_r;
    logic [ADDR_W-1:0] ld_addr;
    logic [ADDR_W-1:0] ld_ptr_new;
    logic [PC_W-1:0] offset_ext;
    logic            rd_we_r;
    logic [4:0]      rd_waddr_r;
    logic [7:0]      rd_wdata_r;
    logic            ptr_we_r;
    logic [1:0]      ptr_sel_r;
    logic [ADDR_W-1:0] ptr_wdata_r;
    logic            dmem_re_r;
    logic [ADDR_W-1:0] dmem_addr_r;
    logic            io_re_r;
    logic            io_we_r;
    logic [4:0]      io_addr_r;
    logic [7:0]      io_wdata_r;
    logic            done_r;
    logic            accept;

    assign cmd_ready = (state_r == ST_IDLE);
    assign accept    = cmd_valid && cmd_ready;

    // ----------------------------------------------------------------
    // branch condition and target
    // ----------------------------------------------------------------

    // condition from the selected flag or the signed pair
    always_comb begin
        cond = 1'b0;
        case (cmd.code)
            // covers global enable at index seven
            OP_BRANCH_FLAG_SET:    cond = flags_r[cmd.bit_idx];
            OP_BRANCH_FLAG_CLEAR:  cond = !flags_r[cmd.bit_idx];
            OP_BRANCH_SIGNED_GE:   cond = !(flags_r[FLAG_N] ^ flags_r[FLAG_V]);
            OP_BRANCH_SIGNED_LESS: cond = flags_r[FLAG_N] ^ flags_r[FLAG_V];
            default:               cond = 1'b0;
        endcase
    end

    assign take = accept && cond;

    assign offset_ext = PC_W'($signed(cmd.offset));

    // ----------------------------------------------------------------
    // shifter
    // ----------------------------------------------------------------

    // result and carry out for the five shift forms
    always_comb begin
        shift_res = rd_value;
        shift_c   = flags_r[FLAG_C];
        is_shift  = 1'b1;
        case (cmd.code)
            OP_SHIFT_LEFT_LOGICAL: begin
                shift_res = {rd_value[MSB-1:0], 1'b0};
                shift_c   = rd_value[MSB];
            end
            OP_SHIFT_RIGHT_LOGICAL: begin
                shift_res = {1'b0, rd_value[MSB:1]};
                shift_c   = rd_value[0];
            end
            OP_SHIFT_RIGHT_ARITHMETIC: begin
                shift_res = {rd_value[MSB], rd_value[MSB:1]};
                shift_c   = rd_value[0];
            end
            OP_ROTATE_LEFT_CARRY: begin
                shift_res = {rd_value[MSB-1:0], flags_r[FLAG_C]};
                shift_c   = rd_value[MSB];
            end
            OP_ROTATE_RIGHT_CARRY: begin
                shift_res = {flags_r[FLAG_C], rd_value[MSB:1]};
                shift_c   = rd_value[0];
            end
            default: begin
                is_shift = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------

    // next flags; branches, io and loads leave them alone
    always_comb begin
        flags_nxt = flags_r;
        if (accept) begin
            if (is_shift) begin
                // z c n v from result
                flags_nxt[FLAG_Z] = (shift_res == BYTE_ZERO);
                flags_nxt[FLAG_C] = shift_c;
                flags_nxt[FLAG_N] = shift_res[MSB];
                flags_nxt[FLAG_V] = shift_res[MSB] ^ shift_c;
            end
            case (cmd.code)
                OP_FLAG_FORCE_ONE_INDEXED:  flags_nxt[cmd.bit_idx] = 1'b1;
                OP_FLAG_FORCE_ZERO_INDEXED: flags_nxt[cmd.bit_idx] = 1'b0;
                OP_COPY_BIT_TO_TRANSFER:    flags_nxt[FLAG_T] = rd_value[cmd.bit_idx];
                default:                    ;
            endcase
        end
    end

    // flag register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            flags_r <= FLAGS_RESET;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------

    // second cycle for taken branches, io and loads
    always_comb begin
        state_nxt = ST_IDLE;
        case (state_r)
            ST_IDLE: begin
                if (take) begin
                    state_nxt = ST_BRANCH;
                end else if (accept && (cmd.code == OP_IO_BIT_FORCE_ONE ||
                                        cmd.code == OP_IO_BIT_FORCE_ZERO)) begin
                    state_nxt = ST_IO;
                end else if (accept && cmd.code == OP_POINTER_LOAD) begin
                    state_nxt = ST_LOAD;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // program counter
    // ----------------------------------------------------------------

    // target saved, loaded in second cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            target_r <= '0;
        end else if (take) begin
            target_r <= pc_r + offset_ext + PC_W'(1);
        end
    end

    // sequential step on single-cycle ops and on finishing io and load ops
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pc_r <= '0;
        end else if (state_r == ST_BRANCH) begin
            pc_r <= target_r;
        end else if (state_r != ST_IDLE || (accept && !take)) begin
            if (state_nxt == ST_IDLE) begin
                pc_r <= pc_r + PC_W'(1);
            end
        end
    end

    // ----------------------------------------------------------------
    // io read-modify-write
    // ----------------------------------------------------------------

    // read first cycle, write back second
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            io_re_r    <= 1'b0;
            io_we_r    <= 1'b0;
            io_addr_r  <= '0;
            io_wdata_r <= BYTE_ZERO;
            bit_r      <= '0;
            io_one_r   <= 1'b0;
        end else begin
            io_re_r <= 1'b0;
            io_we_r <= 1'b0;
            if (state_nxt == ST_IO) begin
                io_re_r   <= 1'b1;
                io_addr_r <= cmd.io_addr;
                bit_r     <= cmd.bit_idx;
                io_one_r  <= (cmd.code == OP_IO_BIT_FORCE_ONE);
            end
            if (state_r == ST_IO) begin
                io_we_r             <= 1'b1;
                io_wdata_r          <= io_rdata;
                io_wdata_r[bit_r]   <= io_one_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // indirect load addressing
    // ----------------------------------------------------------------

    // address and new pointer value per mode
    always_comb begin
        ld_addr    = ptr_value;
        ld_ptr_new = ptr_value;
        case (cmd.mode)
            MODE_POST_INC: ld_ptr_new = ptr_value + ADDR_W'(1);
            MODE_PRE_DEC: begin
                ld_ptr_new = ptr_value - ADDR_W'(1);
                ld_addr    = ld_ptr_new;
            end
            // offset only for y and z
            MODE_DISP: begin
                if (cmd.ptr != PTR_X) begin
                    ld_addr = ptr_value + ADDR_W'(cmd.disp);
                end
            end
            default: ld_addr = ptr_value;
        endcase
    end

    // issue memory read, keep pointer update for the second cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dmem_re_r   <= 1'b0;
            dmem_addr_r <= '0;
            ld_reg_r    <= '0;
            ld_wb_ptr_r <= 1'b0;
            ld_ptr_r    <= '0;
            ptr_sel_r   <= PTR_X;
        end else begin
            dmem_re_r <= 1'b0;
            if (state_nxt == ST_LOAD) begin
                dmem_re_r   <= 1'b1;
                dmem_addr_r <= ld_addr;
                ld_reg_r    <= cmd.reg_idx;
                ptr_sel_r   <= cmd.ptr;
                ld_ptr_r    <= ld_ptr_new;
                ld_wb_ptr_r <= (cmd.mode == MODE_POST_INC) ||
                               (cmd.mode == MODE_PRE_DEC);
            end
        end
    end

    // ----------------------------------------------------------------
    // write back and completion
    // ----------------------------------------------------------------

    // register and pointer write back, done pulse
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_we_r     <= 1'b0;
            rd_waddr_r  <= '0;
            rd_wdata_r  <= BYTE_ZERO;
            ptr_we_r    <= 1'b0;
            ptr_wdata_r <= '0;
            done_r      <= 1'b0;
        end else begin
            rd_we_r  <= 1'b0;
            ptr_we_r <= 1'b0;
            done_r   <= (state_r != ST_IDLE) || (accept && state_nxt == ST_IDLE);
            if (accept && is_shift) begin
                rd_we_r    <= 1'b1;
                rd_waddr_r <= cmd.reg_idx;
                rd_wdata_r <= shift_res;
            end
            if (accept && cmd.code == OP_COPY_TRANSFER_TO_BIT) begin
                rd_we_r                  <= 1'b1;
                rd_waddr_r               <= cmd.reg_idx;
                rd_wdata_r               <= rd_value;
                rd_wdata_r[cmd.bit_idx]  <= flags_r[FLAG_T];
            end
            if (state_r == ST_LOAD) begin
                rd_we_r     <= 1'b1;
                rd_waddr_r  <= ld_reg_r;
                rd_wdata_r  <= dmem_rdata;
                ptr_we_r    <= ld_wb_ptr_r;
                ptr_wdata_r <= ld_ptr_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rd_we        = rd_we_r;
    assign rd_waddr     = rd_waddr_r;
    assign rd_wdata     = rd_wdata_r;
    assign ptr_we       = ptr_we_r;
    assign ptr_sel      = ptr_sel_r;
    assign ptr_wdata    = ptr_wdata_r;
    assign dmem_re      = dmem_re_r;
    assign dmem_addr    = dmem_addr_r;
    assign io_re        = io_re_r;
    assign io_we        = io_we_r;
    assign io_addr      = io_addr_r;
    assign io_wdata     = io_wdata_r;
    assign pc           = pc_r;
    assign status_flags = flags_r;
    assign done         = done_r;

endmodule

// ### tb/far_side_mem.sv
// data memory and io space seen by the execute block
// assumes combinational reads in the strobe cycle
`timescale 1ns/100ps

module far_side_mem (
    // clock
    input  wire logic        clock,
    // data memory
    input  wire logic        dmem_re,
    input  wire logic [15:0] dmem_addr,
    output logic [7:0]       dmem_rdata,
    // io space
    input  wire logic        io_re,
    input  wire logic        io_we,
    input  wire logic [4:0]  io_addr,
    input  wire logic [7:0]  io_wdata,
    output logic [7:0]       io_rdata
);
    logic [7:0] io_mem [32];
    logic [7:0] churn_r;

    // io contents start from a fixed pattern
    initial begin
        churn_r = 8'h00;
        for (int i = 0; i < 32; i++) io_mem[i] = 8'(i) ^ 8'h3c;
    end

    // io writes land, idle data lines keep changing
    always @(posedge clock) begin
        churn_r <= churn_r + 8'h3b;
        if (io_we) io_mem[io_addr] <= io_wdata;
    end

    // read data is only meaningful under its strobe
    assign dmem_rdata = dmem_re ? (dmem_addr[7:0] ^ dmem_addr[15:8] ^ 8'ha5) : churn_r;
    assign io_rdata   = io_re ? io_mem[io_addr] : ~churn_r;
endmodule

// ### tb/exec_checker.sv
// timing and flag checks at the ports of the execute block
// assumes one clock and synchronous active-low reset
`timescale 1ns/100ps

module exec_checker
    import cpu_exec_pkg::*;
#(
    parameter int PC_W   = 12,
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic            clock,
    input wire logic            rst_n,
    // command and operands
    input wire logic            cmd_valid,
    input wire logic            cmd_ready,
    input wire exec_cmd_s       cmd,
    input wire logic [7:0]      rd_value,
    // strobes and state
    input wire logic            rd_we,
    input wire logic            dmem_re,
    input wire logic            io_re,
    input wire logic            io_we,
    input wire logic [PC_W-1:0] pc,
    input wire logic [7:0]      status_flags,
    input wire logic            done
);
    logic            take;
    logic            cond;
    logic            sel_bit;
    logic            nv;
    logic [7:0]      mask;
    logic [PC_W-1:0] off_ext;

    // helper terms taken at the command edge
    assign take    = cmd_valid && cmd_ready;
    assign cond    = status_flags[cmd.bit_idx];
    assign sel_bit = rd_value[cmd.bit_idx];
    assign nv      = status_flags[FLAG_N] ^ status_flags[FLAG_V];
    assign mask    = 8'h01 << cmd.bit_idx;
    assign off_ext = {{(PC_W-7){cmd.offset[6]}}, cmd.offset};

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence two_step_end;
        !done ##1 done;
    endsequence

    a_branch_taken_pc: assert property (take && cmd.code == OP_BRANCH_FLAG_SET && cond
        |=> two_step_end ##0 pc == PC_W'($past(pc, 2) + $past(off_ext, 2) + 1))
        else $error("taken branch target or timing wrong");
    a_branch_skip_pc: assert property (take && cmd.code == OP_BRANCH_FLAG_CLEAR && cond
        |=> done && pc == $past(pc) + 1)
        else $error("untaken branch not sequential");
    a_signed_ge_skip: assert property (take && cmd.code == OP_BRANCH_SIGNED_GE && nv
        |=> done && pc == $past(pc) + 1)
        else $error("signed ge taken on n xor v one");
    a_signed_less_go: assert property (take && cmd.code == OP_BRANCH_SIGNED_LESS && nv
        |=> two_step_end)
        else $error("signed less not taken");
    a_branch_flags_kept: assert property (take && cmd.code inside {OP_BRANCH_FLAG_SET,
        OP_BRANCH_FLAG_CLEAR, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LESS} |=> $stable(status_flags))
        else $error("branch changed flags");
    a_io_bit_steps: assert property (take && cmd.code inside {OP_IO_BIT_FORCE_ONE,
        OP_IO_BIT_FORCE_ZERO} |=> io_re && !cmd_ready ##1 io_we && done && $stable(status_flags))
        else $error("io bit sequence wrong");
    a_shift_one_cycle: assert property (take && cmd.code inside {OP_SHIFT_LEFT_LOGICAL,
        OP_SHIFT_RIGHT_LOGICAL, OP_SHIFT_RIGHT_ARITHMETIC, OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY} |=> done && rd_we
        && status_flags[FLAG_V] == (status_flags[FLAG_N] ^ status_flags[FLAG_C]))
        else $error("shift timing or overflow flag wrong");
    a_flag_force_one: assert property (take && cmd.code == OP_FLAG_FORCE_ONE_INDEXED
        |=> done && status_flags == ($past(status_flags) | $past(mask)))
        else $error("flag set wrong");
    a_flag_force_zero: assert property (take && cmd.code == OP_FLAG_FORCE_ZERO_INDEXED
        |=> done && status_flags == ($past(status_flags) & ~$past(mask)))
        else $error("flag clear wrong");
    a_bit_to_transfer: assert property (take && cmd.code == OP_COPY_BIT_TO_TRANSFER
        |=> status_flags[FLAG_T] == $past(sel_bit)
        && (status_flags & 8'hbf) == ($past(status_flags) & 8'hbf))
        else $error("transfer flag copy wrong");
    a_load_steps: assert property (take && cmd.code == OP_POINTER_LOAD
        |=> dmem_re && !cmd_ready ##1 rd_we && done && $stable(status_flags))
        else $error("load sequence wrong");
endmodule

bind cpu_branch_bit_load_exec exec_checker #(.PC_W(PC_W), .ADDR_W(ADDR_W)) u_chk (
    .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .rd_value(rd_value), .rd_we(rd_we), .dmem_re(dmem_re), .io_re(io_re), .io_we(io_we),
    .pc(pc), .status_flags(status_flags), .done(done));

// ### tb/tb_cpu_branch_bit_load_exec.sv
// self-checking bench for the execute block
// assumes the far side model answers memory and io reads in-cycle
`timescale 1ns/100ps

module tb_cpu_branch_bit_load_exec;
    import cpu_exec_pkg::*;
    localparam int PC_W = 12;

    logic clock, rst_n, cmd_valid, cmd_ready, rd_we, ptr_we, dmem_re, io_re, io_we, done;
    exec_cmd_s cmd;
    logic [7:0] rd_value, rd_wdata, dmem_rdata, io_wdata, io_rdata, status_flags, ef, r, v;
    logic [4:0] rd_waddr, io_addr, seen_wa;
    logic [1:0] ptr_sel, seen_ps;
    logic [15:0] ptr_value, ptr_wdata, dmem_addr, pv, ea, seen_pw, seen_da;
    logic [PC_W-1:0] pc, epc;
    logic [7:0] seen_rd, seen_io_r, seen_io_w;
    logic pw_hit, tk, c;
    int failures, check_count, ncyc, cyc;
    op_e sh [5] = '{OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_SHIFT_RIGHT_ARITHMETIC,
                    OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY};

    cpu_branch_bit_load_exec #(.PC_W(PC_W), .ADDR_W(16)) dut (
        .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
        .rd_value(rd_value), .rd_we(rd_we), .rd_waddr(rd_waddr), .rd_wdata(rd_wdata),
        .ptr_value(ptr_value), .ptr_we(ptr_we), .ptr_sel(ptr_sel), .ptr_wdata(ptr_wdata),
        .dmem_re(dmem_re), .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata), .io_re(io_re),
        .io_we(io_we), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .pc(pc),
        .status_flags(status_flags), .done(done));

    far_side_mem mem (.clock(clock), .dmem_re(dmem_re), .dmem_addr(dmem_addr),
        .dmem_rdata(dmem_rdata), .io_re(io_re), .io_we(io_we), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_rdata(io_rdata));

    // clock source
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    function automatic exec_cmd_s mk(op_e o, logic [2:0] b, logic [6:0] k, logic [1:0] p,
                                     ptr_mode_e m);
        mk = '{o, {2'h2, b}, b, k, 6'h21, p, m, 5'h0b};
    endfunction

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task end_sim;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // one command: valid stays up so commands run back to back
    task run(input exec_cmd_s cc, input logic [7:0] rv, input logic [15:0] p);
        cmd = cc;
        rd_value = rv;
        ptr_value = p;
        cmd_valid = 1'b1;
        pw_hit = 1'b0;
        seen_rd = 'x;
        seen_da = 'x;
        @(negedge clock);
        ncyc = 1;
        forever begin
            if (rd_we === 1'b1) begin seen_rd = rd_wdata; seen_wa = rd_waddr; end
            if (ptr_we === 1'b1) begin pw_hit = 1'b1; seen_pw = ptr_wdata; seen_ps = ptr_sel; end
            if (dmem_re === 1'b1) seen_da = dmem_addr;
            if (io_re === 1'b1) seen_io_r = io_rdata;
            if (io_we === 1'b1) seen_io_w = io_wdata;
            if (done === 1'b1 || ncyc > 4) break;
            @(negedge clock);
            ncyc++;
        end
    endtask

    task step(input int n, input logic [PC_W-1:0] inc);
        epc = epc + inc;
        chk("cycles", 16'(n), 16'(ncyc));
        chk("pc", 16'(epc), 16'(pc));
        chk("flags", 16'(ef), 16'(status_flags));
    endtask

    // hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            end_sim;
        end
    end

    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        rst_n = 1'b0; cmd_valid = 1'b0; cmd = '0; rd_value = 8'h00; ptr_value = 16'h0000;
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        chk("pc", 16'h0000, 16'(pc));
        chk("flags", 16'h0000, 16'(status_flags));
        ef = 8'h00; epc = '0;
        for (int i = 0; i < 8; i++) begin
            run(mk(OP_FLAG_FORCE_ONE_INDEXED, 3'(i), 7'h00, 2'h0, MODE_PLAIN), 8'h00, 16'h0);
            ef[i] = 1'b1;
            step(1, 1);
        end
        for (int i = 0; i < 8; i += 2) begin
            run(mk(OP_FLAG_FORCE_ZERO_INDEXED, 3'(i), 7'h00, 2'h0, MODE_PLAIN), 8'h00, 16'h0);
            ef[i] = 1'b0;
            step(1, 1);
        end
        for (int i = 0; i < 16; i++) begin
            v = {5'h00, 3'(i >> 1)};
            tk = ef[v[2:0]] ^ i[0];
            r = v[0] ? 8'h7a : 8'h05;
            run(mk(i[0] ? OP_BRANCH_FLAG_CLEAR : OP_BRANCH_FLAG_SET, v[2:0], r[6:0], 2'h0,
                   MODE_PLAIN), 8'h00, 16'h0);
            step(tk ? 2 : 1, tk ? {{5{r[6]}}, r[6:0]} + 12'h001 : 12'h001);
        end
        for (int i = 0; i < 4; i++) begin
            if (i == 2) begin
                run(mk(OP_FLAG_FORCE_ZERO_INDEXED, 3'h3, 7'h00, 2'h0, MODE_PLAIN), 8'h00, 16'h0);
                ef[FLAG_V] = 1'b0;
                step(1, 1);
            end
            tk = ef[FLAG_N] ^ ef[FLAG_V] ^ !i[0];
            run(mk(i[0] ? OP_BRANCH_SIGNED_LESS : OP_BRANCH_SIGNED_GE, 3'h0, 7'h03, 2'h0,
                   MODE_PLAIN), 8'h00, 16'h0);
            step(tk ? 2 : 1, tk ? 12'h004 : 12'h001);
        end
        for (int i = 0; i < 15; i++) begin
            v = (i % 3 == 0) ? 8'h81 : (i % 3 == 1) ? 8'h01 : 8'h80;
            case (sh[i / 3])
                OP_SHIFT_LEFT_LOGICAL:     begin r = {v[6:0], 1'b0};     c = v[7]; end
                OP_SHIFT_RIGHT_LOGICAL:    begin r = {1'b0, v[7:1]};     c = v[0]; end
                OP_SHIFT_RIGHT_ARITHMETIC: begin r = {v[7], v[7:1]};     c = v[0]; end
                OP_ROTATE_LEFT_CARRY:      begin r = {v[6:0], ef[0]};    c = v[7]; end
                default:                   begin r = {ef[0], v[7:1]};    c = v[0]; end
            endcase
            ef[FLAG_C] = c; ef[FLAG_Z] = (r == 8'h00); ef[FLAG_N] = r[7]; ef[FLAG_V] = r[7] ^ c;
            run(mk(sh[i / 3], 3'h5, 7'h00, 2'h0, MODE_PLAIN), v, 16'h0);
            step(1, 1);
            chk("shift", 16'(r), 16'(seen_rd));
            chk("waddr", 16'h0015, 16'(seen_wa));
        end
        run(mk(OP_COPY_BIT_TO_TRANSFER, 3'h5, 7'h00, 2'h0, MODE_PLAIN), 8'h20, 16'h0);
        ef[FLAG_T] = 1'b1;
        step(1, 1);
        run(mk(OP_COPY_BIT_TO_TRANSFER, 3'h4, 7'h00, 2'h0, MODE_PLAIN), 8'h20, 16'h0);
        ef[FLAG_T] = 1'b0;
        step(1, 1);
        run(mk(OP_COPY_TRANSFER_TO_BIT, 3'h3, 7'h00, 2'h0, MODE_PLAIN), 8'hff, 16'h0);
        step(1, 1);
        chk("bitload", 16'h00f7, 16'(seen_rd));
        run(mk(OP_IO_BIT_FORCE_ONE, 3'h6, 7'h00, 2'h0, MODE_PLAIN), 8'h00, 16'h0);
        step(2, 1);
        chk("io_set", 16'h0077, 16'(seen_io_w));
        chk("io_addr", 16'h000b, 16'(io_addr));
        run(mk(OP_IO_BIT_FORCE_ZERO, 3'h6, 7'h00, 2'h0, MODE_PLAIN), 8'h00, 16'h0);
        step(2, 1);
        chk("io_back", 16'h0077, 16'(seen_io_r));
        chk("io_clear", 16'h0037, 16'(seen_io_w));
        for (int i = 0; i < 12; i++) begin
            pv = (i % 4 == 2) ? 16'h0000 : 16'h12ff;
            ea = (i % 4 == 2) ? pv - 16'h1 : (i % 4 == 3 && i / 4 != 0) ? pv + 16'h21 : pv;
            run(mk(OP_POINTER_LOAD, 3'h2, 7'h00, 2'(i / 4), ptr_mode_e'(i % 4)), 8'h00, pv);
            step(2, 1);
            chk("daddr", ea, seen_da);
            chk("ldata", 16'(ea[7:0] ^ ea[15:8] ^ 8'ha5), 16'(seen_rd));
            chk("ptr_we", 16'(i % 4 == 1 || i % 4 == 2), 16'(pw_hit));
            if (pw_hit === 1'b1) begin
                chk("ptr", (i % 4 == 1) ? pv + 16'h1 : ea, seen_pw);
                chk("ptr_sel", 16'(i / 4), 16'(seen_ps));
            end
        end
        cmd_valid = 1'b0;
        end_sim;
    end
endmodule
